// *** design/mrs_master_rx.v ***
// master reception control and return code reporting
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "mrs_map.vh"
module mrs_master_rx #(
  parameter AW       = 6,
  parameter DEPTH    = 40,
  parameter WAIT0    = `MRS_WAIT0_CYC,
  parameter WAIT1    = `MRS_WAIT1_CYC
) (
  input  wire       clk_i,
  input  wire       arst_n_i,
  // register port
  input  wire [3:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  output wire       irq_o,
  // bus link events
  input  wire       mode1_i,
  input  wire       arb_won_i,
  input  wire       arb_lost_i,
  input  wire       ctrl_rx_i,
  input  wire       hdr_ok_i,
  input  wire [7:0] slave_addr_i,
  input  wire [7:0] ctrl_bits_i,
  input  wire [7:0] dlen_i,
  input  wire       nak_addr_i,
  input  wire       nak_ctrl_i,
  input  wire       nak_dlen_i,
  input  wire       broadcast_i,
  input  wire       byte_vld_i,
  input  wire [7:0] byte_i,
  input  wire       frame_end_i,
  output wire       start_req_o,
  output wire [3:0] ctrl_bits_o,
  output reg        byte_ack_o,
  output reg        byte_nak_o
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ARB  = 3'd1;
  localparam ST_HDR  = 3'd2;
  localparam ST_DATA = 3'd3;
  localparam ST_FULL = 3'd4;
  localparam CW      = 18;

  // a legal slave-to-master control pattern
  function legal_rx;
    input [3:0] c;
    begin
      legal_rx = (c == 4'h0) || (c == 4'h3) || (c[3:2] == 2'b01);
    end
  endfunction

  reg  [2:0]    state;
  reg  [7:0]    command_reg;
  reg  [7:0]    master_control_reg;
  reg           master_request_flag;
  reg  [7:0]    return_code_reg;
  reg  [7:0]    master_rx_byte_count;
  reg  [7:0]    remaining;
  reg  [AW-1:0] wptr;
  reg  [AW-1:0] rptr;
  reg  [AW:0]   fill;
  reg  [1:0]    hdr_idx;
  reg           rx_ready;
  reg  [3:0]    irq_stat;
  reg  [3:0]    irq_en;
  reg           rd_data_q;
  reg           rd_q;
  reg  [3:0]    addr_q;
  reg           pend_vld;
  reg  [7:0]    pend_byte;

  wire [3:0]    command_code_field = command_reg[3:0];
  wire          interrupt_select_flag = command_reg[`MRS_CMD_IRQSEL];
  wire [7:0]    mem_q;
  wire          full = (fill == DEPTH[AW:0]);
  wire          host_pop = rd_i && (addr_i == `MRS_A_RXDATA) &&
                           (fill != {(AW+1){1'b0}});
  wire          cmd_wr = wr_i && (addr_i == `MRS_A_CMD);
  wire          launch = cmd_wr && (state == ST_IDLE) &&
                         ((wdata_i[3:0] == `MRS_COMMAND_CODE_FIELD_MREQ0) ||
                          (wdata_i[3:0] == `MRS_COMMAND_CODE_FIELD_MREQ1)) &&
                         legal_rx(master_control_reg[3:0]);
  wire          tmr_exp;
  wire          hdr_push = (state == ST_HDR) && rx_ready && !full;
  wire          data_push = (state == ST_DATA) && byte_vld_i && !full;
  wire          full_push = (state == ST_FULL) && pend_vld && !full;
  wire          push = hdr_push || data_push || full_push;
  reg  [7:0]    push_byte;
  reg  [2:0]    next_state;
  reg  [3:0]    next_code;
  reg           code_ev;

  // header byte order: slave address, control, data length
  always @* begin
    push_byte = byte_i;
    if (state == ST_HDR) begin
      case (hdr_idx)
        2'd0:    push_byte = slave_addr_i;
        2'd1:    push_byte = ctrl_bits_i;
        default: push_byte = dlen_i;
      endcase
    end else if (state == ST_FULL) begin
      push_byte = pend_byte;
    end
  end

  mrs_rx_mem #(
    .DW (8),
    .AW (AW)
  ) u_mem (
    .clk_i   (clk_i),
    .we_i    (push),
    .waddr_i (wptr),
    .wdata_i (push_byte),
    .raddr_i (rptr),
    .rdata_o (mem_q)
  );

  mrs_timer #(
    .CW (CW)
  ) u_tmr (
    .clk_i     (clk_i),
    .arst_n_i  (arst_n_i),
    .load_i    ((state == ST_DATA) && byte_vld_i && full),
    .stop_i    (full_push || (state != ST_FULL)),
    .count_i   (mode1_i ? WAIT1[CW-1:0] : WAIT0[CW-1:0]),
    .expired_o (tmr_exp),
    .running_o ()
  );

  // protocol sequencing and return code choice
  always @* begin
    next_state = state;
    next_code  = return_code_reg[7:4];
    code_ev    = 1'b0;
    case (state)
      ST_IDLE: begin
        if (launch) begin
          next_state = ST_ARB;
        end
      end
      ST_ARB: begin
        if (arb_lost_i) begin
          next_state = ST_IDLE;
          next_code  = `MRS_RC_ABORT;
          code_ev    = 1'b1;
        end else if (!broadcast_i &&
                     (nak_addr_i || nak_ctrl_i || nak_dlen_i)) begin
          next_state = ST_IDLE;
          next_code  = `MRS_RC_ABORT;
          code_ev    = 1'b1;
        end else if (arb_won_i && hdr_ok_i) begin
          next_state = ST_HDR;
          next_code  = `MRS_RC_STARTED;
          code_ev    = 1'b1;
        end
      end
      ST_HDR: begin
        if (hdr_push && hdr_idx == 2'd2) begin
          next_state = (dlen_i == 8'h00) ? ST_IDLE : ST_DATA;
          if (dlen_i == 8'h00) begin
            next_code = `MRS_RC_DONE;
            code_ev   = 1'b1;
          end
        end
      end
      ST_DATA: begin
        if (data_push && remaining == 8'h01) begin
          next_state = ST_IDLE;
          next_code  = `MRS_RC_DONE;
          code_ev    = 1'b1;
        end else if (byte_vld_i && full) begin
          next_state = ST_FULL;
          next_code  = `MRS_RC_FULL;
          code_ev    = 1'b1;
        end else if (frame_end_i) begin
          next_state = ST_IDLE;
          next_code  = `MRS_RC_ABORT;
          code_ev    = 1'b1;
        end
      end
      ST_FULL: begin
        if (full_push) begin
          next_state = (remaining == 8'h01) ? ST_IDLE : ST_DATA;
          if (remaining == 8'h01) begin
            next_code = `MRS_RC_DONE;
            code_ev   = 1'b1;
          end
        end else if (tmr_exp || frame_end_i) begin
          next_state = ST_IDLE;
          next_code  = `MRS_RC_ABORT;
          code_ev    = 1'b1;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // control state, flags and counters
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state                <= ST_IDLE;
      command_reg          <= 8'h00;
      master_control_reg   <= 8'h00;
      master_request_flag  <= 1'b0;
      return_code_reg      <= `MRS_RCODE_RESET;
      master_rx_byte_count <= 8'h00;
      remaining            <= 8'h00;
      hdr_idx              <= 2'd0;
      rx_ready             <= 1'b0;
      pend_vld             <= 1'b0;
      pend_byte            <= 8'h00;
      byte_ack_o           <= 1'b0;
      byte_nak_o           <= 1'b0;
    end else begin
      state      <= next_state;
      byte_ack_o <= data_push || full_push;
      byte_nak_o <= (state == ST_FULL) && tmr_exp;
      if (cmd_wr) begin
        command_reg <= wdata_i;
      end
      if (wr_i && addr_i == `MRS_A_MCTL) begin
        master_control_reg <= wdata_i;
      end
      if (launch) begin
        master_rx_byte_count <= 8'h00;
        master_request_flag  <= 1'b1;
      end
      // request flag drops at end or abort
      if (code_ev && next_state == ST_IDLE) begin
        master_request_flag <= 1'b0;
      end
      if (code_ev) begin
        return_code_reg <= {next_code, return_code_reg[3:0]};
      end
      if (state == ST_ARB && ctrl_rx_i) begin
        rx_ready <= 1'b1;
      end else if (next_state == ST_IDLE) begin
        rx_ready <= 1'b0;
      end
      if (state == ST_ARB && next_state == ST_HDR) begin
        hdr_idx <= 2'd0;
        // count set to three at start
        master_rx_byte_count <= `MRS_HDR_BYTES;
        remaining <= dlen_i;
      end
      if (hdr_push) begin
        hdr_idx <= hdr_idx + 2'd1;
      end
      if (data_push || full_push) begin
        master_rx_byte_count <= master_rx_byte_count + 8'h01;
        remaining <= remaining - 8'h01;
      end
      if (state == ST_DATA && byte_vld_i && full) begin
        pend_vld  <= 1'b1;
        pend_byte <= byte_i;
      end else if (state != ST_FULL || full_push) begin
        pend_vld <= 1'b0;
      end
    end
  end

  // buffer pointers survive the end of a frame
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wptr <= {AW{1'b0}};
      rptr <= {AW{1'b0}};
      fill <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wptr <= (wptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                wptr + 1'b1;
      end
      if (host_pop) begin
        rptr <= (rptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                rptr + 1'b1;
      end
      if (push && !host_pop) begin
        fill <= fill + 1'b1;
      end else if (host_pop && !push) begin
        fill <= fill - 1'b1;
      end
    end
  end

  // interrupt status: set wins over a clear in the same cycle
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_stat <= 4'h0;
      irq_en   <= 4'h0;
    end else begin
      if (wr_i && addr_i == `MRS_A_IRQ_EN) begin
        irq_en <= wdata_i[3:0];
      end
      irq_stat <= (irq_stat & ~((wr_i && addr_i == `MRS_A_IRQ_CLR) ?
                  wdata_i[3:0] : 4'h0)) |
                  {(code_ev && next_code == `MRS_RC_ABORT),
                   (code_ev && next_code == `MRS_RC_DONE),
                   (code_ev && next_code == `MRS_RC_FULL),
                   (code_ev && (next_code != return_code_reg[7:4]) &&
                    interrupt_select_flag)};
    end
  end

  assign irq_o = |(irq_stat & irq_en);

  // register read data, one cycle after the strobe
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_q      <= 1'b0;
      rd_data_q <= 1'b0;
      addr_q    <= 4'h0;
    end else begin
      rd_q      <= rd_i;
      rd_data_q <= host_pop;
      addr_q    <= addr_i;
    end
  end

  always @* begin
    rdata_o = 8'h00;
    if (rd_q) begin
      case (addr_q)
        `MRS_A_CMD:      rdata_o = command_reg;
        `MRS_A_MCTL:     rdata_o = master_control_reg;
        `MRS_A_RXDATA:   rdata_o = rd_data_q ? mem_q : 8'h00;
        `MRS_A_COUNT:    rdata_o = master_rx_byte_count;
        `MRS_A_FLAG:     rdata_o = {7'h00, master_request_flag};
        `MRS_A_RCODE:    rdata_o = return_code_reg;
        `MRS_A_IRQ_STAT: rdata_o = {4'h0, irq_stat};
        `MRS_A_IRQ_EN:   rdata_o = {4'h0, irq_en};
        default:         rdata_o = 8'h00;
      endcase
    end
  end

  assign start_req_o = (state == ST_ARB);
  // control bits offered on the bus
  assign ctrl_bits_o = master_control_reg[3:0];
endmodule // mrs_master_rx
`default_nettype wire

// *** design/mrs_map.vh ***
// register map, return codes and timing constants of the master receive block
`ifndef MRS_MAP_VH
`define MRS_MAP_VH
// register addresses (4-bit address space)
`define MRS_A_CMD        4'h0
`define MRS_A_MCTL       4'h1
`define MRS_A_RXDATA     4'h2
`define MRS_A_COUNT      4'h3
`define MRS_A_FLAG       4'h4
`define MRS_A_RCODE      4'h8
`define MRS_A_IRQ_STAT   4'h9
`define MRS_A_IRQ_CLR    4'hA
`define MRS_A_IRQ_EN     4'hB
// command register fields
`define MRS_CMD_IRQSEL   4
`define MRS_COMMAND_CODE_FIELD_MREQ0   4'h8
`define MRS_COMMAND_CODE_FIELD_MREQ1   4'h9
// return codes
`define MRS_RC_STARTED   4'h4
`define MRS_RC_FULL      4'h5
`define MRS_RC_DONE      4'h6
`define MRS_RC_ABORT     4'h7
`define MRS_RCODE_RESET  8'hFF
// interrupt status bits
`define MRS_IRQ_RC       0
`define MRS_IRQ_FULL     1
`define MRS_IRQ_DONE     2
`define MRS_IRQ_ABORT    3
// buffer-full read windows
`define MRS_WAIT0_US     1570
`define MRS_WAIT1_US     390
`define MRS_CLK_MHZ      125
`define MRS_WAIT0_CYC    (`MRS_WAIT0_US * `MRS_CLK_MHZ)
`define MRS_WAIT1_CYC    (`MRS_WAIT1_US * `MRS_CLK_MHZ)
`define MRS_HDR_BYTES    8'h03
`endif

// *** design/mrs_rx_mem.v ***
// receive buffer storage: simple dual port, registered read
`timescale 1ns/1ps
`default_nettype none
module mrs_rx_mem #(
  parameter DW = 8,
  parameter AW = 6
) (
  input  wire          clk_i,
  input  wire          we_i,
  input  wire [AW-1:0] waddr_i,
  input  wire [DW-1:0] wdata_i,
  input  wire [AW-1:0] raddr_i,
  output reg  [DW-1:0] rdata_o
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // storage has no reset; pointers guard it
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule // mrs_rx_mem
`default_nettype wire

// *** design/mrs_timer.v ***
// down counter for the buffer-full read window
`timescale 1ns/1ps
`default_nettype none
module mrs_timer #(
  parameter CW = 18
) (
  input  wire          clk_i,
  input  wire          arst_n_i,
  input  wire          load_i,
  input  wire          stop_i,
  input  wire [CW-1:0] count_i,
  output wire          expired_o,
  output wire          running_o
);
  reg [CW-1:0] cnt;
  reg          run;

  // load wins over stop; expiry is one cycle at count zero
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= {CW{1'b0}};
      run <= 1'b0;
    end else if (load_i) begin
      cnt <= count_i;
      run <= 1'b1;
    end else if (stop_i) begin
      run <= 1'b0;
    end else if (run) begin
      if (cnt == {CW{1'b0}}) begin
        run <= 1'b0;
      end else begin
        cnt <= cnt - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  assign expired_o = run && (cnt == {CW{1'b0}}) && !load_i && !stop_i;
  assign running_o = run;
endmodule // mrs_timer
`default_nettype wire

// *** verification/mrs_master_rx_checker.sv ***
// port-level assertions for the master receive block
`timescale 1ns/1ps
`default_nettype none
module mrs_master_rx_checker #(
  parameter int WAIT0 = 50,
  parameter int WAIT1 = 20
) (
  input wire logic       clk_i,
  input wire logic       arst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       irq_o,
  input wire logic       mode1_i,
  input wire logic       byte_vld_i,
  input wire logic       start_req_o,
  input wire logic [3:0] ctrl_bits_o,
  input wire logic       byte_nak_o
);
  logic [19:0] gap;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // cycles since a byte was offered; saturates so it never wraps
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) gap <= '0;
    else if (byte_vld_i) gap <= '0;
    else if (gap != '1) gap <= gap + 20'h0_0001;
  end
  sequence s_launch;
    wr_i && addr_i == 4'h0 && wdata_i[3:1] == 3'b100;
  endsequence
  sequence s_bad_launch;
    s_launch ##0 (!start_req_o && ctrl_bits_o != 4'h0
      && ctrl_bits_o != 4'h3 && ctrl_bits_o[3:2] != 2'b01);
  endsequence
  property p_refuse; s_bad_launch |=> !start_req_o; endproperty
  property p_launch_src;
    $rose(start_req_o) |-> $past(wr_i && addr_i == 4'h0
      && wdata_i[3:1] == 3'b100);
  endproperty
  property p_ctrl_hold;
    $changed(ctrl_bits_o) |-> $past(wr_i && addr_i == 4'h1);
  endproperty
  property p_rcode_low; rd_i && addr_i == 4'h8 |=> rdata_o[3:0] == 4'hF;
  endproperty
  property p_unmapped;
    rd_i && addr_i inside {[4'h5:4'h7], [4'hC:4'hF]} |=> rdata_o == 8'h00;
  endproperty
  property p_rd_idle; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
  property p_irq_off;
    wr_i && addr_i == 4'hB && wdata_i == 8'h00 |=> !irq_o ##1 !irq_o;
  endproperty
  property p_nak_wait;
    byte_nak_o |-> gap + 20'h0_0002 >= (mode1_i ? WAIT1 : WAIT0);
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad launch taken");
  a_launch_src: assert property (p_launch_src) else $error("no launch");
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("ctrl moved");
  a_rcode_low: assert property (p_rcode_low) else $error("rc low");
  a_unmapped: assert property (p_unmapped) else $error("unmapped");
  a_rd_idle: assert property (p_rd_idle) else $error("rdata idle");
  a_irq_off: assert property (p_irq_off) else $error("irq masked");
  a_nak_wait: assert property (p_nak_wait) else $error("nak early");
endmodule // mrs_master_rx_checker
bind mrs_master_rx mrs_master_rx_checker #(.WAIT0(WAIT0), .WAIT1(WAIT1))
  u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .irq_o(irq_o), .mode1_i(mode1_i), .byte_vld_i(byte_vld_i),
  .start_req_o(start_req_o), .ctrl_bits_o(ctrl_bits_o),
  .byte_nak_o(byte_nak_o));
`default_nettype wire

// *** verification/mrs_link_model.sv ***
// far-side slave model: arbitration, header fields and data bytes
`timescale 1ns/1ps
`default_nettype none
module mrs_link_model (
  input  wire logic        clk_i,
  input  wire logic        req_i,
  input  wire logic        ack_i,
  input  wire logic        nak_i,
  output var  logic [7:0]  ev_o,
  output var  logic [31:0] dat_o
);
  int   n;
  logic naked = 1'b0;
  // quiet bus lines at time zero
  initial begin
    ev_o = 8'h00;
    dat_o = 32'h0000_0000;
  end
  // one-cycle event pulse launched just after an edge
  task automatic pulse(input int b);
    @(posedge clk_i);
    ev_o[b] <= 1'b1;
    @(posedge clk_i);
    ev_o[b] <= 1'b0;
  endtask
  // kind 0 runs a frame, any other kind is the event bit that kills it
  task automatic frame(input int kind, input logic [7:0] len, input int nb,
                       input logic [7:0] sa, ctl, d0);
    naked = 1'b0;
    n = 0;
    while (!req_i && n < 50) begin
      @(posedge clk_i);
      #1 n++;
    end
    @(posedge clk_i);
    dat_o[31:8] <= {sa, ctl, len};
    if (kind == 0 || kind == 5) pulse(0);
    pulse(kind == 0 ? 1 : kind);
    if (kind != 0) return;
    repeat (4) @(posedge clk_i);
    dat_o[31:8] <= ~{sa, ctl, len};  // released: never the last value
    for (int i = 0; i < nb && !naked; i++) begin
      dat_o[7:0] <= d0 + i[7:0];
      pulse(7);
      dat_o[7:0] <= ~(d0 + i[7:0]);
      n = 0;
      // byte offered for its valid pulse only, then awaited until stored or refused; the answers are one-cycle
      // pulses, so they are read at the edge before the design moves on
      do begin
        @(posedge clk_i);
        n++;
      end while (!ack_i && !nak_i && n < 400);
      naked = nak_i;
    end
    if (!naked && nb < len) pulse(6);
  endtask
endmodule // mrs_link_model
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench for the master receive block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_i, arst_n_i, wr_i, rd_i, mode1_i, irq_o, req, ack, nak;
  logic        bcast;
  logic [3:0]  addr_i, cbits;
  logic [7:0]  wdata_i, rdata_o, v, sa, d0, len, ev;
  logic [31:0] dat;
  logic [3:0]  ctl [6] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
  int          n_fail = 0, checks_done = 0, cycles = 0, n;
  mrs_master_rx #(.DEPTH(8), .WAIT0(50), .WAIT1(20)) dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .mode1_i(mode1_i), .arb_won_i(ev[1]), .arb_lost_i(ev[2]),
    .ctrl_rx_i(ev[0]), .hdr_ok_i(ev[1]), .slave_addr_i(dat[31:24]),
    .ctrl_bits_i(dat[23:16]), .dlen_i(dat[15:8]), .nak_addr_i(ev[3]),
    .nak_ctrl_i(ev[4]), .nak_dlen_i(ev[5]), .broadcast_i(bcast),
    .byte_vld_i(ev[7]), .byte_i(dat[7:0]), .frame_end_i(ev[6]),
    .start_req_o(req), .ctrl_bits_o(cbits), .byte_ack_o(ack),
    .byte_nak_o(nak));
  mrs_link_model u_link (.clk_i(clk_i), .req_i(req), .ack_i(ack),
    .nak_i(nak), .ev_o(ev), .dat_o(dat));
  task automatic chk(input logic [7:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #2;
  endtask
  // read data is taken mid-cycle, clear of the edge updates
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    v = rdata_o;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    rd(a);
    chk(v, e);
  endtask
  task automatic launch(input logic [3:0] c, input logic [7:0] cmd);
    wr(4'h1, {4'h0, c});
    wr(4'h0, cmd);
    rdchk(4'h4, 8'h01);
    rdchk(4'h3, 8'h00);
    chk({4'h0, cbits}, {4'h0, c});
  endtask
  task automatic stat(input logic [7:0] e);
    rdchk(4'h9, e);
    chk({7'h00, irq_o}, 8'h01);
    wr(4'hA, 8'hFF);
    chk({7'h00, irq_o}, 8'h00);
  endtask
  // expected buffer byte j of a frame: header first, then the data ramp
  function automatic logic [7:0] exp_byte(input int j,
                                          input logic [7:0] c, l);
    return j == 0 ? sa : j == 1 ? c : j == 2 ? l : d0 + 8'(j - 3);
  endfunction
  // drain header then data, then expect an empty buffer
  task automatic pop(input int skip, input logic [7:0] c, l, input int nd);
    for (int j = skip; j < nd + 3; j++)
      rdchk(4'h2, exp_byte(j, c, l));
    rdchk(4'h2, 8'h00);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // free-running 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // watchdog on the whole run
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    {arst_n_i, wr_i, rd_i, mode1_i, bcast, addr_i, wdata_i} = '0;
    n = $urandom(32'h428a);
    sa = 8'($urandom);
    d0 = 8'($urandom);
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rdchk(4'h8, 8'hFF);
    rdchk(4'hF, 8'h00);
    wr(4'h9, 8'hFF);
    rdchk(4'h9, 8'h00);
    wr(4'hB, 8'h0F);
    wr(4'h0, 8'h10);
    wr(4'h1, 8'h0A);
    wr(4'h0, 8'h18);
    rdchk(4'h4, 8'h00);
    $display("reset and refusal test done");
    for (int i = 0; i < 6; i++) begin
      len = i == 0 ? 8'h00 : 8'($urandom_range(1, 4));
      sa = 8'($urandom);
      d0 = 8'($urandom);
      launch(ctl[i], {7'h0C, i[0]});
      u_link.frame(0, len, int'(len), sa, {4'h0, ctl[i]}, d0);
      rdchk(4'h8, 8'h6F);
      rdchk(4'h4, 8'h00);
      rdchk(4'h3, len + 8'h03);
      stat(8'h05);
      pop(0, {4'h0, ctl[i]}, len, int'(len));
    end
    $display("normal reception test done");
    // a nak on a broadcast frame must not abort; arbitration loss ends it
    launch(4'h3, 8'h18);
    @(posedge clk_i);
    bcast <= 1'b1;
    u_link.frame(3, 8'h03, 1, sa, 8'h03, d0);
    bcast <= 1'b0;
    rdchk(4'h4, 8'h01);
    rdchk(4'h8, 8'h6F);
    for (int k = 2; k < 7; k++) begin
      // last abort runs with the interrupt selection off
      launch(4'h3, k == 6 ? 8'h08 : 8'h18);
      u_link.frame(k == 6 ? 0 : k, 8'h03, 1, sa, 8'h03, d0);
      rdchk(4'h8, 8'h7F);
      rdchk(4'h4, 8'h00);
      rdchk(4'h3, k == 6 ? 8'h04 : 8'h00);
      // a repeated abort leaves the code as it was: no change request
      stat(k == 2 ? 8'h09 : 8'h08);
      if (k == 6) pop(0, 8'h03, 8'h03, 1);
    end
    $display("abort test done");
    for (int m = 0; m < 2; m++) begin
      @(posedge clk_i);
      mode1_i <= m[0];
      if (m == 1) wr(4'hB, 8'h00);
      launch(4'h7, 8'h19);
      fork
        u_link.frame(0, 8'h06, 6, sa, 8'h07, d0);
        begin
          n = 0;
          do begin
            rd(4'h8);
            n++;
          end while (v !== 8'h5F && n < 60);
          chk(v, 8'h5F);
          if (m == 0) rdchk(4'h2, sa);
        end
      join
      if (m == 0) begin
        rdchk(4'h8, 8'h6F);
        rdchk(4'h3, 8'h09);
        stat(8'h07);
        pop(1, 8'h07, 8'h06, 6);
      end else begin
        chk({7'h00, irq_o}, 8'h00);
        rdchk(4'h8, 8'h7F);
        rdchk(4'h4, 8'h00);
        rdchk(4'h3, 8'h08);
        chk({7'h00, u_link.naked}, 8'h01);
        wr(4'hB, 8'h0F);
        stat(8'h0B);
        pop(0, 8'h07, 8'h06, 5);
      end
    end
    $display("buffer full test done");
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
